/* inc/qubp_mem_if.sv */
// interface between access engine and register store
`timescale 1ns/1ns
interface qubp_mem_if;
    import qubp_pkg::*;
    logic                 wrEn;
    logic [MEM_AW-1:0]    wrAddr;
    logic [DATA_W-1:0]    wrData;
    logic [MEM_AW-1:0]    rdAddr;
    logic [DATA_W-1:0]    rdData;
    modport engine (output wrEn, output wrAddr, output wrData,
                    output rdAddr, input rdData);
    modport store  (input wrEn, input wrAddr, input wrData,
                    input rdAddr, output rdData);
endinterface : qubp_mem_if

/* inc/qubp_pkg.sv */
// constants and types shared by the host bus port
package qubp_pkg;
    localparam int          NUM_CHAN      = 4;
    localparam int          DATA_W        = 8;
    localparam int          IDX_W         = 3;
    localparam int          REGS_PER_CHAN = 8;
    localparam int          MEM_AW        = 5;
    localparam int          GATE_BIT      = 3;
    localparam logic [2:0]  MODEM_CTRL_IDX = 3'h4;
    localparam logic [7:0]  REG_RESET     = 8'h00;
    localparam logic [7:0]  MODEM_CTRL_RESET = 8'h00;
    localparam logic [0:0]  FORCE_TIE_NONE = 1'b0;
    typedef enum logic [1:0] {
        FORCE_PIN,
        FORCE_TIE_HIGH,
        FORCE_TIE_LOW
    } qubp_force_t;
    typedef enum {
        ST_IDLE,
        ST_READ,
        ST_WRITE
    } qubp_state_t;
endpackage : qubp_pkg

/* rtl/qubp_host_port.sv */
// host parallel bus port: strobe and direction-line styles, irq pins
`timescale 1ns/1ns

// Notes on behaviour
// - bus style input high picks strobe style, low picks direction-line style
// - strobe style read falls, indexed byte driven, host samples on rise
// - strobe style write falls starts cycle, rise stores data byte
// - direction-line style write strobe is direction: high read, low write
// - strobe style has four active-low selects, one per channel
// - direction-line style uses first select as device select
// - direction-line style uses second and third selects as channel bits
// - strobe style irq pin driven when gate bit or force set, floats otherwise
// - direction-line style first irq is shared open-drain active low
// - build option may tie force input high or low
// - eight-bit data bus driven only during reads
// - three index lines pick register inside the selected channel
module qubp_host_port #(
    parameter qubp_pkg::qubp_force_t FORCE_TIE = qubp_pkg::FORCE_PIN
) (
    input  wire logic                          core_clk,
    input  wire logic                          rst_n,
    input  wire logic                          busStyleSel,
    input  wire logic                          read_strobe_n,
    input  wire logic                          write_strobe_n,
    input  wire logic                          chan_select_a_n,
    input  wire logic                          chan_select_b_n,
    input  wire logic                          chan_select_c_n,
    input  wire logic                          chan_select_d_n,
    input  wire logic [qubp_pkg::IDX_W-1:0]    reg_index,
    input  wire logic [qubp_pkg::DATA_W-1:0]   dataIn,
    output logic      [qubp_pkg::DATA_W-1:0]   dataOut,
    output logic                               dataOe_n,
    input  wire logic                          irq_force_enable,
    input  wire logic [qubp_pkg::NUM_CHAN-1:0] chanIrqReq,
    output logic      [qubp_pkg::NUM_CHAN-1:0] chanIrqOut,
    output logic      [qubp_pkg::NUM_CHAN-1:0] chanIrqOe_n
);
    import qubp_pkg::*;

    localparam int SYNC_W = 8 + IDX_W + DATA_W;

    logic [SYNC_W-1:0] rawPins;
    logic [SYNC_W-1:0] syncPins;
    logic [SYNC_W-1:0] pinReset;
    logic              sStyle;
    logic              sRd_n;
    logic              sWr_n;
    logic [3:0]        sCs_n;
    logic [IDX_W-1:0]  sIdx;
    logic [DATA_W-1:0] sData;
    logic              sForce;

    assign rawPins = {busStyleSel, read_strobe_n, write_strobe_n,
                      chan_select_d_n, chan_select_c_n,
                      chan_select_b_n, chan_select_a_n,
                      reg_index, dataIn, irq_force_enable};
    // strobes and selects idle high after reset, style defaults to strobe
    assign pinReset = {1'b1, 1'b1, 1'b1, 4'hf,
                       {IDX_W{1'b0}}, {DATA_W{1'b0}}, 1'b0};
    assign {sStyle, sRd_n, sWr_n, sCs_n, sIdx, sData, sForce} = syncPins;

    // strobes are asynchronous to core_clk
    qubp_sync #(.W(SYNC_W)) uSync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .asyncIn  (rawPins),
        .resetVal (pinReset),
        .syncOut  (syncPins)
    );

    qubp_mem_if memBus ();

    qubp_reg_store uStore (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .mem      (memBus)
    );

    // decode active channel one-hot from selects in either style
    function automatic logic [NUM_CHAN-1:0] chanDecode(
        input logic       style,
        input logic [3:0] cs_n
    );
        logic [NUM_CHAN-1:0] hot;
        hot = '0;
        if (style) begin
            hot = ~cs_n;
            if ($countones(hot) != 1) begin
                hot = '0;
            end
        end else if (!cs_n[0]) begin
            hot = NUM_CHAN'(1) << {cs_n[2], cs_n[1]};
        end
        return hot;
    endfunction : chanDecode

    function automatic logic [1:0] hotToNum(input logic [NUM_CHAN-1:0] hot);
        logic [1:0] n;
        n = 2'h0;
        for (int i = 0; i < NUM_CHAN; i++) begin
            if (hot[i]) begin
                n = 2'(i);
            end
        end
        return n;
    endfunction : hotToNum

    qubp_state_t         state_reg;
    qubp_state_t         state_next;
    logic [1:0]          chan_reg;
    logic [1:0]          chan_next;
    logic [IDX_W-1:0]    idx_reg;
    logic [IDX_W-1:0]    idx_next;
    logic [DATA_W-1:0]   wrData_reg;
    logic [DATA_W-1:0]   wrData_next;
    logic                dataOe_n_reg;
    logic                dataOe_n_next;
    logic                rdValid_reg;
    logic                rdValid_next;
    logic [NUM_CHAN-1:0] gate_reg;
    logic [NUM_CHAN-1:0] gate_next;
    logic                wrEn;
    logic [NUM_CHAN-1:0] selHot;
    logic                rdActive;
    logic                wrActive;

    always_comb begin
        selHot   = chanDecode(sStyle, sCs_n);
        rdActive = 1'b0;
        wrActive = 1'b0;
        if (sStyle) begin
            rdActive = (|selHot) && !sRd_n && sWr_n;
            wrActive = (|selHot) && !sWr_n && sRd_n;
        end else begin
            // read strobe ignored here; fourth select ignored
            // access only with device select low
            rdActive = !sCs_n[0] && sWr_n;
            wrActive = !sCs_n[0] && !sWr_n;
        end
    end

    always_comb begin
        state_next    = state_reg;
        chan_next     = chan_reg;
        idx_next      = idx_reg;
        wrData_next   = wrData_reg;
        dataOe_n_next = 1'b1;
        rdValid_next  = 1'b0;
        wrEn          = 1'b0;
        unique case (state_reg)
            ST_IDLE: begin
                if (rdActive) begin
                    state_next = ST_READ;
                end else if (wrActive) begin
                    state_next = ST_WRITE;
                end
                chan_next = hotToNum(selHot);
                idx_next  = sIdx;
            end
            ST_READ: begin
                rdValid_next  = 1'b1;
                dataOe_n_next = !rdValid_reg;
                if (!rdActive) begin
                    state_next    = ST_IDLE;
                    dataOe_n_next = 1'b1;
                end
            end
            ST_WRITE: begin
                wrData_next = sData;
                if (!wrActive) begin
                    wrEn       = 1'b1;
                    state_next = ST_IDLE;
                end
            end
        endcase
        gate_next = gate_reg;
        if (wrEn && idx_reg == MODEM_CTRL_IDX) begin
            gate_next[chan_reg] = wrData_reg[GATE_BIT];
        end
    end

    // the write takes the data seen one cycle before the strobe rose
    assign memBus.wrEn   = wrEn;
    assign memBus.wrAddr = {chan_reg, idx_reg};
    assign memBus.wrData = wrData_reg;
    assign memBus.rdAddr = {chan_reg, idx_reg};

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_reg    <= ST_IDLE;
            chan_reg     <= 2'h0;
            idx_reg      <= '0;
            wrData_reg   <= REG_RESET;
            dataOe_n_reg <= 1'b1;
            rdValid_reg  <= 1'b0;
            gate_reg     <= {NUM_CHAN{MODEM_CTRL_RESET[GATE_BIT]}};
        end else begin
            state_reg    <= state_next;
            chan_reg     <= chan_next;
            idx_reg      <= idx_next;
            wrData_reg   <= wrData_next;
            dataOe_n_reg <= dataOe_n_next;
            rdValid_reg  <= rdValid_next;
            gate_reg     <= gate_next;
        end
    end

    logic [DATA_W-1:0]   dataOut_reg;
    logic [DATA_W-1:0]   dataOut_next;
    logic [NUM_CHAN-1:0] irqOut_reg;
    logic [NUM_CHAN-1:0] irqOut_next;
    logic [NUM_CHAN-1:0] irqOe_n_reg;
    logic [NUM_CHAN-1:0] irqOe_n_next;
    logic                forceEff;

    always_comb begin
        unique case (FORCE_TIE)
            FORCE_TIE_HIGH: forceEff = 1'b1;
            FORCE_TIE_LOW:  forceEff = 1'b0;
            default:        forceEff = sForce;
        endcase
        dataOut_next = rdValid_reg ? memBus.rdData : dataOut_reg;
        irqOut_next  = '0;
        irqOe_n_next = '1;
        if (sStyle) begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                // force overrides gate; gate enables pin
                irqOut_next[i]  = chanIrqReq[i];
                irqOe_n_next[i] = !(forceEff || gate_reg[i]);
            end
        end else begin
            // open drain, pulls low on any request
            // force input assumed low here, so ignored
            irqOut_next[0]  = 1'b0;
            irqOe_n_next[0] = !(|chanIrqReq);
            irqOe_n_next[NUM_CHAN-1:1] = '0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            dataOut_reg <= REG_RESET;
            irqOut_reg  <= '0;
            irqOe_n_reg <= '1;
        end else begin
            dataOut_reg <= dataOut_next;
            irqOut_reg  <= irqOut_next;
            irqOe_n_reg <= irqOe_n_next;
        end
    end

    assign dataOut     = dataOut_reg;
    assign dataOe_n    = dataOe_n_reg;
    assign chanIrqOut  = irqOut_reg;
    assign chanIrqOe_n = irqOe_n_reg;

    a_write_stores: assert property (@(posedge core_clk) disable iff (!rst_n)
        state_reg == ST_WRITE && !wrActive |-> wrEn && $past(wrActive))
        else $error("write not stored on strobe release");
    a_read_drive: assert property (@(posedge core_clk) disable iff (!rst_n)
        state_reg == ST_READ && rdActive ##1 state_reg == ST_READ
        && rdActive |=> !dataOe_n)
        else $error("bus not driven during held read");
    a_bus_float: assert property (@(posedge core_clk) disable iff (!rst_n)
        $past(state_reg) != ST_READ |-> dataOe_n)
        else $error("bus driven outside read");
    a_gate_enable: assert property (@(posedge core_clk) disable iff (!rst_n)
        sStyle && $stable(sStyle) && gate_reg[1] |=> !chanIrqOe_n[1])
        else $error("gated irq pin not driven");
    a_force_enable: assert property (@(posedge core_clk) disable iff (!rst_n)
        sStyle && forceEff |=> chanIrqOe_n == '0)
        else $error("forced irq pins not driven");
    a_unused_low: assert property (@(posedge core_clk) disable iff (!rst_n)
        !sStyle |=> chanIrqOe_n[3:1] == '0 && chanIrqOut[3:1] == '0)
        else $error("unused irq pins not low");
    a_shared_irq: assert property (@(posedge core_clk) disable iff (!rst_n)
        !sStyle && (|chanIrqReq) |=> !chanIrqOe_n[0] && !chanIrqOut[0])
        else $error("shared irq not pulled low");
    a_devsel_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
        !sStyle && sCs_n[0] |-> !rdActive && !wrActive)
        else $error("access without device select");
    a_chan_decode: assert property (@(posedge core_clk) disable iff (!rst_n)
        !sStyle && !sCs_n[0] |-> selHot[{sCs_n[2], sCs_n[1]}])
        else $error("channel bits decode wrong");
endmodule : qubp_host_port

/* rtl/qubp_reg_store.sv */
// channel register storage, registered read data
`timescale 1ns/1ns
module qubp_reg_store (
    input wire logic     core_clk,
    input wire logic     rst_n,
    qubp_mem_if.store    mem
);
    import qubp_pkg::*;
    logic [DATA_W-1:0] memArr [NUM_CHAN*REGS_PER_CHAN];
    logic [DATA_W-1:0] rdData_reg;
    logic [DATA_W-1:0] rdData_next;

    always_comb begin
        rdData_next = memArr[mem.rdAddr];
        if (mem.wrEn && mem.wrAddr == mem.rdAddr) begin
            rdData_next = mem.wrData;
        end
    end

    always_ff @(posedge core_clk) begin
        if (mem.wrEn) begin
            memArr[mem.wrAddr] <= mem.wrData;
        end
        if (!rst_n) begin
            rdData_reg <= REG_RESET;
        end else begin
            rdData_reg <= rdData_next;
        end
    end

    assign mem.rdData = rdData_reg;
endmodule : qubp_reg_store

/* rtl/qubp_sync.sv */
// two-flop synchroniser for a vector of pins
`timescale 1ns/1ns
module qubp_sync #(
    parameter int W = 1
) (
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] asyncIn,
    input  wire logic [W-1:0] resetVal,
    output logic      [W-1:0] syncOut
);
    logic [W-1:0] stage1_reg;
    logic [W-1:0] stage2_reg;
    logic [W-1:0] stage1_next;
    logic [W-1:0] stage2_next;

    always_comb begin
        stage1_next = asyncIn;
        stage2_next = stage1_reg;
    end

    // reset value is a constant at each instance
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            stage1_reg <= resetVal;
            stage2_reg <= resetVal;
        end else begin
            stage1_reg <= stage1_next;
            stage2_reg <= stage2_next;
        end
    end

    assign syncOut = stage2_reg;
endmodule : qubp_sync

/* tb/qubp_host_model.sv */
// host processor model driving the parallel bus port
`timescale 1ns/1ns
module qubp_host_model (
    input  wire logic       core_clk,
    input  wire logic [7:0] dataOut,
    input  wire logic       dataOe_n,
    output logic            read_strobe_n,
    output logic            write_strobe_n,
    output logic      [3:0] csN,
    output logic      [2:0] reg_index,
    output logic      [7:0] dataIn
);
    logic [7:0] hostBus;
    // wire level: device wins only while it drives
    assign dataIn = (dataOe_n === 1'b0) ? dataOut : hostBus;
    initial begin
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
        csN = 4'hF;
        reg_index = 3'h0;
        hostBus = 8'h00;
    end
    task automatic access(input logic style, input logic wr,
                          input logic [3:0] cs, input logic [2:0] idx,
                          input logic [7:0] wd, output logic [7:0] rd,
                          output logic oe);
        @(negedge core_clk);
        reg_index = idx;
        csN = cs;
        if (wr) hostBus = wd;
        // unused strobe stays high, direction line
        read_strobe_n = style ? wr : 1'b1;
        write_strobe_n = !wr;
        repeat (8) @(negedge core_clk);
        // host takes the byte just before the strobe rises
        rd = dataIn;
        oe = dataOe_n;
        // rising strobe, or deselect in direction-line style, ends the write; bus released after
        read_strobe_n = 1'b1;
        csN = 4'hF;
        if (style) write_strobe_n = 1'b1;
        @(negedge core_clk);
        write_strobe_n = 1'b1;
        // released bus shows no stale value
        hostBus = ~hostBus;
        repeat (7) @(negedge core_clk);
    endtask : access
endmodule : qubp_host_model

/* tb/test_quad_uart_host_bus_port.sv */
// self-checking bench for the host bus port
`timescale 1ns/1ns
module test_quad_uart_host_bus_port;
    import qubp_pkg::*;
    typedef struct packed {
        logic       s;
        logic [1:0] c;
        logic [2:0] i;
        logic [7:0] d;
    } qubp_row_t;
    logic       core_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       busStyleSel = 1'b1;
    logic       irq_force_enable = 1'b0;
    logic [3:0] chanIrqReq = 4'h0;
    logic       read_strobe_n, write_strobe_n, dataOe_n;
    logic [3:0] csN, chanIrqOut, chanIrqOe_n, tieOe_n, lowOe_n;
    logic [2:0] reg_index;
    logic [7:0] dataIn, dataOut, rd;
    logic       oe;
    int         mismatches = 0;
    int         testsRun = 0;
    qubp_row_t  rows [8] = '{'{1'h1, 2'h0, 3'h0, 8'hA5},
        '{1'h1, 2'h1, 3'h7, 8'h3C}, '{1'h1, 2'h2, 3'h3, 8'h81},
        '{1'h1, 2'h3, 3'h5, 8'h7E}, '{1'h0, 2'h0, 3'h7, 8'h5A},
        '{1'h0, 2'h1, 3'h2, 8'hC3}, '{1'h0, 2'h2, 3'h6, 8'h18},
        '{1'h0, 2'h3, 3'h1, 8'hE7}};
    always #25 core_clk = ~core_clk;
    qubp_host_model host (.core_clk(core_clk), .dataOut(dataOut),
        .dataOe_n(dataOe_n), .read_strobe_n(read_strobe_n),
        .write_strobe_n(write_strobe_n), .csN(csN),
        .reg_index(reg_index), .dataIn(dataIn));
    qubp_host_port uut (.core_clk(core_clk), .rst_n(rst_n),
        .busStyleSel(busStyleSel), .read_strobe_n(read_strobe_n),
        .write_strobe_n(write_strobe_n), .chan_select_a_n(csN[0]),
        .chan_select_b_n(csN[1]), .chan_select_c_n(csN[2]),
        .chan_select_d_n(csN[3]), .reg_index(reg_index),
        .dataIn(dataIn), .dataOut(dataOut), .dataOe_n(dataOe_n),
        .irq_force_enable(irq_force_enable), .chanIrqReq(chanIrqReq),
        .chanIrqOut(chanIrqOut), .chanIrqOe_n(chanIrqOe_n));
    // same pins with the force input tied high at build time
    qubp_host_port #(.FORCE_TIE(FORCE_TIE_HIGH)) uutTie (
        .core_clk(core_clk), .rst_n(rst_n),
        .busStyleSel(busStyleSel), .read_strobe_n(read_strobe_n),
        .write_strobe_n(write_strobe_n), .chan_select_a_n(csN[0]),
        .chan_select_b_n(csN[1]), .chan_select_c_n(csN[2]),
        .chan_select_d_n(csN[3]), .reg_index(reg_index),
        .dataIn(dataIn), .dataOut(), .dataOe_n(),
        .irq_force_enable(irq_force_enable), .chanIrqReq(chanIrqReq),
        .chanIrqOut(), .chanIrqOe_n(tieOe_n));
    // force input tied low: in strobe style only the gate bit enables a pin
    qubp_host_port #(.FORCE_TIE(FORCE_TIE_LOW)) uutLow (
        .core_clk(core_clk), .rst_n(rst_n),
        .busStyleSel(busStyleSel), .read_strobe_n(read_strobe_n),
        .write_strobe_n(write_strobe_n), .chan_select_a_n(csN[0]),
        .chan_select_b_n(csN[1]), .chan_select_c_n(csN[2]),
        .chan_select_d_n(csN[3]), .reg_index(reg_index),
        .dataIn(dataIn), .dataOut(), .dataOe_n(),
        .irq_force_enable(irq_force_enable), .chanIrqReq(chanIrqReq),
        .chanIrqOut(), .chanIrqOe_n(lowOe_n));
    function automatic logic [3:0] csFor(input logic s,
                                         input logic [1:0] c);
        return s ? ~(4'h1 << c) : {1'b1, c, 1'b0};
    endfunction : csFor
    task automatic check8(input logic [7:0] got, input logic [7:0] exp,
                          input string m);
        testsRun++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask : check8
    task automatic completeRun;
        $display("checks %0d, mismatches %0d", testsRun, mismatches);
        if (mismatches == 0 && testsRun > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : completeRun
    // style input is synchronised, so let it settle before access
    task automatic setStyle(input logic s);
        @(negedge core_clk);
        busStyleSel = s;
        repeat (5) @(negedge core_clk);
    endtask : setStyle
    task automatic doReset;
        @(negedge core_clk);
        rst_n = 1'b0;
        repeat (8) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge core_clk);
    endtask : doReset
    initial begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        completeRun;
    end
    initial begin
        doReset;
        check8({7'h0, dataOe_n}, 8'h01, "bus driven after reset");
        for (int k = 0; k < 8; k++) begin
            setStyle(rows[k].s);
            host.access(rows[k].s, 1'b1, csFor(rows[k].s, rows[k].c),
                        rows[k].i, rows[k].d, rd, oe);
        end
        // read back in the other style, so both maps must agree
        for (int k = 0; k < 8; k++) begin
            setStyle(!rows[k].s);
            host.access(!rows[k].s, 1'b0, csFor(!rows[k].s, rows[k].c),
                        rows[k].i, 8'h00, rd, oe);
            check8(rd, rows[k].d, "read data");
            check8({7'h0, oe}, 8'h00, "bus not driven");
            check8({7'h0, dataOe_n}, 8'h01, "bus not released");
        end
        setStyle(1'b1);
        host.access(1'b1, 1'b1, 4'hC, 3'h0, 8'hFF, rd, oe);
        setStyle(1'b0);
        host.access(1'b0, 1'b1, 4'h1, 3'h0, 8'hFF, rd, oe);
        host.access(1'b0, 1'b0, 4'h1, 3'h0, 8'h00, rd, oe);
        check8({7'h0, oe}, 8'h01, "unselected read drove bus");
        host.access(1'b0, 1'b0, 4'h8, 3'h0, 8'h00, rd, oe);
        check8(rd, 8'hA5, "refused write stored");
        doReset;
        setStyle(1'b1);
        chanIrqReq = 4'hA;
        repeat (4) @(negedge core_clk);
        check8({4'h0, chanIrqOe_n}, 8'h0F, "irq gate default");
        check8({4'h0, tieOe_n}, 8'h00, "tied force");
        host.access(1'b1, 1'b1, 4'hD, MODEM_CTRL_IDX, 8'h08, rd, oe);
        check8({4'h0, chanIrqOe_n}, 8'h0D, "irq gate set");
        check8({7'h0, chanIrqOut[1]}, 8'h01, "irq value");
        irq_force_enable = 1'b1;
        repeat (5) @(negedge core_clk);
        check8({4'h0, chanIrqOe_n}, 8'h00, "force enable");
        check8({4'h0, chanIrqOut}, 8'h0A, "forced irq value");
        check8({4'h0, lowOe_n}, 8'h0D, "tied low force");
        // force must be low before leaving strobe style
        irq_force_enable = 1'b0;
        setStyle(1'b0);
        check8({4'h0, chanIrqOe_n}, 8'h00, "shared irq enable");
        check8({4'h0, chanIrqOut}, 8'h00, "shared irq level");
        chanIrqReq = 4'h0;
        repeat (5) @(negedge core_clk);
        check8({4'h0, chanIrqOe_n}, 8'h01, "shared irq idle");
        completeRun;
    end
endmodule : test_quad_uart_host_bus_port
